// *** rtl/ddr4_mode_config_cmd_decode.sv ***
/*
 Command decoder with mode register five/six/seven handling and parity checking.
 Assumes command and address pins are synchronous to ref_clk_in; the rest of the
 device consumes the decoded command pulse and the configuration outputs.
*/
module ddr4_mode_config_cmd_decode #(
	parameter int ADDR_W = 14,
	parameter int BURST_LEN = 4,
	parameter bit WIDE_ORG = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic chip_select_n_in,
	input wire logic activate_select_n_in,
	input wire logic row_strobe_addr16_in,
	input wire logic column_strobe_addr15_in,
	input wire logic write_enable_addr14_in,
	input wire logic clock_enable_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [1:0] bank_addr_in,
	input wire logic [1:0] bank_group_sel_in,
	input wire logic parity_input_in,
	input wire logic crc_error_in,
	input wire logic power_down_in,
	input wire logic termination_control_in,
	output logic [3:0] cmd_out,
	output logic cmd_valid_out,
	output logic [16:0] cmd_addr_out,
	output logic parity_error_out,
	output logic crc_error_out,
	output logic [2:0] parity_latency_out,
	output logic parity_check_out,
	output logic parity_persist_out,
	output logic term_buf_pd_out,
	output logic nominal_term_active_out,
	output logic bus_invert_read_out,
	output logic bus_invert_write_out,
	output logic write_byte_mask_out,
	output logic write_mask_apply_out,
	output logic [2:0] same_group_column_gap_out,
	output logic ref_train_out,
	output logic ref_range_out,
	output logic [5:0] ref_value_out,
	output logic [13:0] data_reference_level_out,
	output logic burst_busy_out
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		mode_cfg_pkg::cmd_e cmd;
		logic valid;
		logic [16:0] caddr;
		logic par_err;
		logic crc_err;
		logic [2:0] par_lat;
		logic persist;
		logic term_buf;
		logic [2:0] nom_term;
		logic rd_inv;
		logic wr_inv;
		logic wmask;
		logic [2:0] col_gap;
		logic train;
		logic range;
		logic [5:0] ref_val;
		mode_cfg_pkg::burst_e burst;
		logic [3:0] beat;
		logic mask_apply;
	} state_s;

	state_s st;
	state_s next_st;

	logic [16:0] full_addr;
	logic [2:0] sel;
	logic par_calc;
	logic checking;
	logic par_bad;
	logic is_mode_set;
	mode_cfg_pkg::cmd_e raw_cmd;

	// ****************************************
	// Command decode
	// ****************************************
	always_comb begin
		full_addr = 17'h00000;
		full_addr[ADDR_W-1:0] = addr_in;
		if (!activate_select_n_in) begin
			full_addr[16] = row_strobe_addr16_in;
			full_addr[15] = column_strobe_addr15_in;
			full_addr[14] = write_enable_addr14_in;
		end
		sel = {bank_group_sel_in[0], bank_addr_in};
		// Parity spans activate, the shared pins, address, bank address and bank group bits only
		par_calc = ^{activate_select_n_in, row_strobe_addr16_in, column_strobe_addr15_in,
			write_enable_addr14_in, addr_in, bank_addr_in, bank_group_sel_in};
		raw_cmd = mode_cfg_pkg::CMD_DESELECT;
		if (clock_enable_in && !chip_select_n_in) begin
			if (!activate_select_n_in) begin
				raw_cmd = mode_cfg_pkg::CMD_ACTIVATE;
			end else begin
				unique case ({row_strobe_addr16_in, column_strobe_addr15_in,
					write_enable_addr14_in})
					3'b000: raw_cmd = mode_cfg_pkg::CMD_MODE_SET;
					3'b001: raw_cmd = mode_cfg_pkg::CMD_REFRESH;
					3'b010: raw_cmd = mode_cfg_pkg::CMD_PRECHARGE;
					3'b100: raw_cmd = mode_cfg_pkg::CMD_WRITE;
					3'b101: raw_cmd = mode_cfg_pkg::CMD_READ;
					3'b110: raw_cmd = mode_cfg_pkg::CMD_ZQ_CAL;
					3'b111: raw_cmd = mode_cfg_pkg::CMD_NOP;
					default: raw_cmd = mode_cfg_pkg::CMD_RESERVED;
				endcase
			end
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.valid = 1'b0;
		next_st.mask_apply = 1'b0;
		// Parity checked only with a nonzero latency, and after an error only while persist is set
		checking = (st.par_lat != 3'h0) && (st.persist || !st.par_err);
		par_bad = checking && (raw_cmd != mode_cfg_pkg::CMD_DESELECT)
			&& (par_calc != parity_input_in);
		is_mode_set = (raw_cmd == mode_cfg_pkg::CMD_MODE_SET) && !par_bad;
		if (raw_cmd != mode_cfg_pkg::CMD_DESELECT && !par_bad) begin
			next_st.cmd = raw_cmd;
			next_st.valid = 1'b1;
			next_st.caddr = full_addr;
		end
		if (is_mode_set) begin
			unique case (sel)
				mode_cfg_pkg::SEL_MODE_REG_ONE: begin
					next_st.nom_term = full_addr[mode_cfg_pkg::NOM_TERM_LSB +: 3];
				end
				mode_cfg_pkg::SEL_MODE_REG_FIVE: begin
					next_st.par_lat = full_addr[mode_cfg_pkg::PAR_LAT_LSB +: 3];
					next_st.crc_err = full_addr[mode_cfg_pkg::CRC_ERR_BIT];
					next_st.par_err = full_addr[mode_cfg_pkg::PAR_ERR_BIT];
					if (st.nom_term != 3'h0) begin
						next_st.term_buf = full_addr[mode_cfg_pkg::TERM_BUF_PD_BIT];
					end
					next_st.persist = full_addr[mode_cfg_pkg::PAR_PERSIST_BIT];
					next_st.rd_inv = full_addr[mode_cfg_pkg::READ_INVERT_BIT];
					next_st.wr_inv = full_addr[mode_cfg_pkg::WRITE_INVERT_BIT];
					// Mask loses to write inversion; shared pin cannot do both
					next_st.wmask = full_addr[mode_cfg_pkg::WRITE_MASK_BIT]
						&& !full_addr[mode_cfg_pkg::WRITE_INVERT_BIT];
				end
				mode_cfg_pkg::SEL_MODE_REG_SIX: begin
					next_st.train = full_addr[mode_cfg_pkg::REF_TRAIN_BIT];
					next_st.range = full_addr[mode_cfg_pkg::REF_RANGE_BIT];
					// Settings beyond forty-nine are clamped to the last step
					if (full_addr[5:0] > mode_cfg_pkg::REF_LAST_SETTING) begin
						next_st.ref_val = mode_cfg_pkg::REF_LAST_SETTING;
					end else begin
						next_st.ref_val = full_addr[5:0];
					end
					next_st.col_gap = full_addr[mode_cfg_pkg::COL_GAP_LSB +: 3];
				end
				mode_cfg_pkg::SEL_MODE_REG_SEVEN: begin
					next_st.valid = 1'b0;
				end
				mode_cfg_pkg::SEL_CONTROL_WORD: begin
					next_st.valid = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// Hardware set wins over a clear in the same cycle
		if (par_bad) begin
			next_st.par_err = 1'b1;
		end
		if (crc_error_in) begin
			next_st.crc_err = 1'b1;
		end
		// Bursts cannot be cut short; new reads or writes are not tracked meanwhile
		unique case (st.burst)
			mode_cfg_pkg::BURST_IDLE: begin
				if (next_st.valid && raw_cmd == mode_cfg_pkg::CMD_READ) begin
					next_st.burst = mode_cfg_pkg::BURST_READ;
					next_st.beat = 4'(BURST_LEN - 1);
				end else if (next_st.valid && raw_cmd == mode_cfg_pkg::CMD_WRITE) begin
					next_st.burst = mode_cfg_pkg::BURST_WRITE;
					next_st.beat = 4'(BURST_LEN - 1);
				end
			end
			mode_cfg_pkg::BURST_READ, mode_cfg_pkg::BURST_WRITE: begin
				next_st.mask_apply = WIDE_ORG && st.wmask
					&& (st.burst == mode_cfg_pkg::BURST_WRITE);
				if (st.beat == 4'h0) begin
					next_st.burst = mode_cfg_pkg::BURST_IDLE;
				end else begin
					next_st.beat = st.beat - 4'h1;
				end
			end
			default: begin
				next_st.burst = mode_cfg_pkg::BURST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign cmd_out = st.cmd;
	assign cmd_valid_out = st.valid;
	assign cmd_addr_out = st.caddr;
	assign parity_error_out = st.par_err;
	assign crc_error_out = st.crc_err;
	assign parity_latency_out = st.par_lat;
	assign parity_check_out = (st.par_lat != 3'h0) && (st.persist || !st.par_err);
	assign parity_persist_out = st.persist;
	assign term_buf_pd_out = st.term_buf;
	// Power-down with term_buf clear: no nominal termination, park may still apply
	assign nominal_term_active_out = (st.nom_term != 3'h0) && termination_control_in
		&& !(power_down_in && !st.term_buf);
	assign bus_invert_read_out = WIDE_ORG && st.rd_inv;
	assign bus_invert_write_out = WIDE_ORG && st.wr_inv;
	assign write_byte_mask_out = WIDE_ORG && st.wmask;
	assign write_mask_apply_out = st.mask_apply;
	assign same_group_column_gap_out = st.col_gap;
	assign ref_train_out = st.train;
	assign ref_range_out = st.range;
	assign ref_value_out = st.ref_val;
	assign data_reference_level_out = (st.range ? mode_cfg_pkg::RANGE_TWO_BASE
		: mode_cfg_pkg::RANGE_ONE_BASE) + 14'(st.ref_val * mode_cfg_pkg::REF_STEP);
	assign burst_busy_out = (st.burst != mode_cfg_pkg::BURST_IDLE);
endmodule // ddr4_mode_config_cmd_decode

// *** rtl/mode_cfg_pkg.sv ***
/*
 Constants for the mode register five/six/seven decode and command decoder.
 Assumes a single synchronous clock domain and command pins already registered.
*/
package mode_cfg_pkg;
	// ****************************************
	// Mode register selectors {bank group bit 0, bank address[1:0]}
	// ****************************************
	localparam logic [2:0] SEL_MODE_REG_ONE = 3'h1;
	localparam logic [2:0] SEL_MODE_REG_FIVE = 3'h5;
	localparam logic [2:0] SEL_MODE_REG_SIX = 3'h6;
	localparam logic [2:0] SEL_MODE_REG_SEVEN = 3'h3;
	localparam logic [2:0] SEL_CONTROL_WORD = 3'h7;
	// ****************************************
	// Mode register five fields
	// ****************************************
	localparam int PAR_LAT_LSB = 0;
	localparam int PAR_LAT_W = 3;
	localparam int CRC_ERR_BIT = 3;
	localparam int PAR_ERR_BIT = 4;
	localparam int TERM_BUF_PD_BIT = 5;
	localparam int PAR_PERSIST_BIT = 9;
	localparam int WRITE_MASK_BIT = 10;
	localparam int WRITE_INVERT_BIT = 11;
	localparam int READ_INVERT_BIT = 12;
	// ****************************************
	// Mode register six fields
	// ****************************************
	localparam int REF_VALUE_LSB = 0;
	localparam int REF_VALUE_W = 6;
	localparam int REF_RANGE_BIT = 6;
	localparam int REF_TRAIN_BIT = 7;
	localparam int COL_GAP_LSB = 10;
	localparam int COL_GAP_W = 3;
	// ****************************************
	// Mode register one: nominal termination field
	// ****************************************
	localparam int NOM_TERM_LSB = 8;
	localparam int NOM_TERM_W = 3;
	// ****************************************
	// Reference level in hundredths of a percent of io_supply
	// ****************************************
	localparam logic [13:0] RANGE_ONE_BASE = 14'h1770;
	localparam logic [13:0] RANGE_TWO_BASE = 14'h1194;
	localparam logic [13:0] REF_STEP = 14'h0041;
	localparam logic [5:0] REF_LAST_SETTING = 6'h31;
	// ****************************************
	// Decoded commands
	// ****************************************
	typedef enum logic [3:0] {
		CMD_DESELECT, CMD_ACTIVATE, CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE,
		CMD_WRITE, CMD_READ, CMD_ZQ_CAL, CMD_NOP, CMD_RESERVED
	} cmd_e;
	typedef enum logic [1:0] {
		BURST_IDLE, BURST_READ, BURST_WRITE
	} burst_e;
endpackage

// *** tb/ctl_model.sv ***
/*
 Controller model driving the command pins.
 Assumes the bench clock; changes pins on falling edges only.
*/
module ctl_model (
	input wire logic clk_in,
	output logic cke_out,
	output logic cs_n_out,
	output logic [3:0] pins_out,
	output logic [13:0] addr_out,
	output logic [2:0] sel_out,
	output logic par_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cke_out = 1'b1;
		cs_n_out = 1'b1;
		pins_out = 4'hf;
		addr_out = 14'h0;
		sel_out = 3'h0;
		par_out = 1'b0;
	end
	// Deselect flips every pin, address, select and parity line so a stale value never passes for a command
	task automatic cmd(input logic [3:0] c, input logic [13:0] a, input logic [2:0] s,
		input logic bad);
		@(negedge clk_in);
		cs_n_out = 1'b0;
		pins_out = c;
		addr_out = a;
		sel_out = s;
		par_out = ^{c, a, s} ^ bad;
		@(negedge clk_in);
		cs_n_out = 1'b1;
		pins_out = ~c;
		addr_out = ~a;
		sel_out = ~s;
		par_out = ~par_out;
	endtask
endmodule // ctl_model

// *** tb/ddr4_mode_config_cmd_decode_bench.sv ***
/*
 Bench for the command decoder.
 Assumes the controller model and the bound checker.
*/
module ddr4_mode_config_cmd_decode_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] MS = 4'h8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic crc = 1'b0;
	logic pd = 1'b0;
	logic termination_control = 1'b0;
	logic cke, cs_n, par, vld, perr, cerr, pchk, nom;
	logic [3:0] pins, cmd;
	logic [13:0] addr, lvl;
	logic [2:0] sel, lat;
	logic [16:0] ca;
	logic [5:0] rv;
	logic ppst, tbuf, bir, biw, wbm, wma, trn, rng, busy;
	logic [2:0] gap;
	int errors = 0;
	int tests_run = 0;
	ctl_model ctl (.clk_in(clk), .cke_out(cke), .cs_n_out(cs_n), .pins_out(pins),
		.addr_out(addr), .sel_out(sel), .par_out(par));
	ddr4_mode_config_cmd_decode #(.WIDE_ORG(1'b1)) uut (
		.ref_clk_in(clk), .sys_rst_in(rst), .chip_select_n_in(cs_n),
		.activate_select_n_in(pins[3]), .row_strobe_addr16_in(pins[2]),
		.column_strobe_addr15_in(pins[1]), .write_enable_addr14_in(pins[0]),
		.clock_enable_in(cke), .addr_in(addr), .bank_addr_in(sel[1:0]),
		.bank_group_sel_in({1'b0, sel[2]}), .parity_input_in(par), .crc_error_in(crc),
		.power_down_in(pd), .termination_control_in(termination_control), .cmd_out(cmd),
		.cmd_valid_out(vld), .cmd_addr_out(ca), .parity_error_out(perr),
		.crc_error_out(cerr), .parity_latency_out(lat), .parity_check_out(pchk),
		.parity_persist_out(ppst), .term_buf_pd_out(tbuf), .nominal_term_active_out(nom),
		.bus_invert_read_out(bir), .bus_invert_write_out(biw), .write_byte_mask_out(wbm),
		.write_mask_apply_out(wma), .same_group_column_gap_out(gap), .ref_train_out(trn),
		.ref_range_out(rng), .ref_value_out(rv), .data_reference_level_out(lvl),
		.burst_busy_out(busy));
	// ****
	// Checks and scenarios
	// ****
	task automatic chk(input string n, input logic [16:0] s, input logic [16:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic t_config;
		ctl.cmd(MS, 14'h0001, 3'h5, 1'b0);
		chk("valid", vld, 17'h1);
		chk("latency", lat, 17'h1);
		chk("check", pchk, 17'h1);
		ctl.cmd(MS, 14'h00bf, 3'h6, 1'b0);
		chk("value", rv, 17'h31);
		chk("level", lvl, 17'h23e1);
		chk("train", trn, 17'h1);
		ctl.cmd(MS, 14'h00c0, 3'h6, 1'b0);
		chk("level", lvl, 17'h1194);
		chk("range", rng, 17'h1);
	endtask
	task automatic t_reserved;
		for (int i = 0; i < 2; i++) begin
			ctl.cmd(MS, 14'h0000, i == 0 ? 3'h7 : 3'h3, 1'b0);
			chk("valid", vld, 17'h0);
			chk("latency", lat, 17'h1);
		end
	endtask
	task automatic t_parity;
		ctl.cmd(4'h5, 14'h0005, 3'h0, 1'b1);
		chk("valid", vld, 17'h0);
		chk("perr", perr, 17'h1);
		ctl.cmd(4'h5, 14'h0005, 3'h0, 1'b1);
		chk("valid", vld, 17'h1);
		ctl.cmd(MS, 14'h0201, 3'h5, 1'b0);
		chk("perr", perr, 17'h0);
		chk("persist", ppst, 17'h1);
		ctl.cmd(4'h5, 14'h0005, 3'h0, 1'b1);
		ctl.cmd(4'h5, 14'h0005, 3'h0, 1'b1);
		chk("valid", vld, 17'h0);
		chk("perr", perr, 17'h1);
		ctl.cmd(MS, 14'h0001, 3'h5, 1'b0);
	endtask
	task automatic t_crc;
		@(negedge clk);
		crc = 1'b1;
		@(negedge clk);
		crc = 1'b0;
		chk("crc", cerr, 17'h1);
		ctl.cmd(4'h5, 14'h0000, 3'h0, 1'b0);
		chk("crc", cerr, 17'h1);
		ctl.cmd(MS, 14'h0001, 3'h5, 1'b0);
		chk("crc", cerr, 17'h0);
	endtask
	task automatic t_decode;
		ctl.cmd(4'h5, 14'h1234, 3'h0, 1'b0);
		chk("cmd", cmd, 17'h1);
		chk("addr", ca, 17'h15234);
		ctl.cmd(4'hd, 14'h0000, 3'h0, 1'b0);
		chk("cmd", cmd, 17'h6);
		ctl.cmd(4'hc, 14'h0000, 3'h0, 1'b0);
		chk("cmd", cmd, 17'h5);
		repeat (4) @(negedge clk);
	endtask
	task automatic t_term;
		ctl.cmd(MS, 14'h0100, 3'h1, 1'b0);
		termination_control = 1'b1;
		pd = 1'b1;
		@(negedge clk);
		chk("nominal", nom, 17'h0);
		pd = 1'b0;
		@(negedge clk);
		chk("nominal", nom, 17'h1);
	endtask
	// Runs after t_term, so nominal termination is on at entry
	task automatic t_options;
		ctl.cmd(MS, 14'h0e20, 3'h5, 1'b0);
		chk("term buffer", tbuf, 17'h1);
		chk("persist", ppst, 17'h1);
		chk("mask", wbm, 17'h0);
		chk("write invert", biw, 17'h1);
		chk("read invert", bir, 17'h0);
		ctl.cmd(MS, 14'h0400, 3'h5, 1'b0);
		chk("mask", wbm, 17'h1);
		chk("write invert", biw, 17'h0);
		ctl.cmd(4'hc, 14'h0000, 3'h0, 1'b0);
		chk("busy", busy, 17'h1);
		chk("mask apply", wma, 17'h0);
		ctl.cmd(4'hd, 14'h0000, 3'h0, 1'b0);
		chk("cmd", cmd, 17'h6);
		chk("mask apply", wma, 17'h1);
		@(negedge clk);
		chk("busy", busy, 17'h1);
		@(negedge clk);
		chk("busy", busy, 17'h0);
		ctl.cmd(4'hd, 14'h0000, 3'h0, 1'b0);
		@(negedge clk);
		chk("mask apply", wma, 17'h0);
		repeat (4) @(negedge clk);
		ctl.cmd(MS, 14'h1000, 3'h5, 1'b0);
		chk("read invert", bir, 17'h1);
		ctl.cmd(MS, 14'h1c00, 3'h6, 1'b0);
		chk("column gap", gap, 17'h7);
		chk("train", trn, 17'h0);
		ctl.cmd(MS, 14'h0000, 3'h1, 1'b0);
		ctl.cmd(MS, 14'h0020, 3'h5, 1'b0);
		chk("term buffer", tbuf, 17'h0);
	endtask
	task automatic close_out;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Whole run is well under a hundred commands
	initial begin
		#5000;
		errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_config();
		t_reserved();
		t_parity();
		t_crc();
		t_decode();
		t_term();
		t_options();
		close_out();
	end
endmodule // ddr4_mode_config_cmd_decode_bench

// *** tb/mc_chk_assertions.sv ***
/*
 Checker on the decoder ports.
 Assumes one clock domain; bound to every decoder instance.
*/
module mc_chk #(
	parameter int ADDR_W = 14
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic chip_select_n_in,
	input wire logic activate_select_n_in,
	input wire logic row_strobe_addr16_in,
	input wire logic column_strobe_addr15_in,
	input wire logic write_enable_addr14_in,
	input wire logic clock_enable_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [1:0] bank_addr_in,
	input wire logic [1:0] bank_group_sel_in,
	input wire logic parity_input_in,
	input wire logic crc_error_in,
	input wire logic power_down_in,
	input wire logic [3:0] cmd_out,
	input wire logic cmd_valid_out,
	input wire logic [16:0] cmd_addr_out,
	input wire logic parity_error_out,
	input wire logic crc_error_out,
	input wire logic [2:0] parity_latency_out,
	input wire logic parity_check_out,
	input wire logic parity_persist_out,
	input wire logic term_buf_pd_out,
	input wire logic nominal_term_active_out,
	input wire logic ref_range_out,
	input wire logic [5:0] ref_value_out,
	input wire logic [13:0] data_reference_level_out
);
	// ****
	// Properties
	// ****
	logic sel;
	logic ms;
	logic bad;
	logic [2:0] msel;
	logic [2:0] pins;
	assign pins = {row_strobe_addr16_in, column_strobe_addr15_in, write_enable_addr14_in};
	assign sel = !chip_select_n_in && clock_enable_in;
	assign ms = sel && activate_select_n_in && pins == 3'h0;
	assign msel = {bank_group_sel_in[0], bank_addr_in};
	assign bad = ^{activate_select_n_in, pins, addr_in, bank_addr_in, bank_group_sel_in}
		^ parity_input_in;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence keep_par_s;
		parity_error_out && !(ms && msel == 3'h5 && !addr_in[4]);
	endsequence
	sequence keep_crc_s;
		crc_error_out && !(ms && msel == 3'h5 && !addr_in[3]);
	endsequence
	par_set_a: assert property (
		sel && bad && parity_check_out |=> parity_error_out && !cmd_valid_out)
		else $error("parity fault not caught");
	par_hold_a: assert property (keep_par_s |=> parity_error_out)
		else $error("parity flag dropped");
	crc_hold_a: assert property (keep_crc_s |=> crc_error_out)
		else $error("crc flag dropped");
	crc_set_a: assert property (crc_error_in |=> crc_error_out)
		else $error("crc flag not set");
	check_enable_a: assert property (
		parity_check_out == (parity_latency_out != 3'h0
		&& (!parity_error_out || parity_persist_out)))
		else $error("parity check enable wrong");
	reserved_sel_a: assert property (
		ms && (msel == 3'h7 || msel == 3'h3) |=> !cmd_valid_out
		&& $stable(parity_latency_out) && $stable(ref_value_out))
		else $error("reserved mode set acted");
	act_decode_a: assert property (
		sel && !activate_select_n_in && !(bad && parity_check_out) |=> cmd_valid_out
		&& cmd_out == 4'h1 && cmd_addr_out == $past({pins, addr_in}))
		else $error("activate decode wrong");
	ref_level_a: assert property (
		ref_value_out <= 6'h31 && data_reference_level_out
		== (ref_range_out ? 14'h1194 : 14'h1770) + 14'h0041 * ref_value_out)
		else $error("reference level wrong");
	nom_term_a: assert property (
		power_down_in && !term_buf_pd_out |-> !nominal_term_active_out)
		else $error("termination in power down");
endmodule // mc_chk
bind ddr4_mode_config_cmd_decode mc_chk #(.ADDR_W(ADDR_W)) chk (.*);
